// ---- hw/osc_ctrl_defs.svh ----
// Offsets, field positions, reset values of the oscillator registers.
// Assumes inclusion by bare name from the hw/ folder.
`ifndef OSC_CTRL_DEFS_SVH
`define OSC_CTRL_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OSC_CONTROL_OFS     12'h000
`define OSC_STATUS_OFS      12'h004
`define OSC_TUNING_OFS      12'h008

// ****************************************
// Control fields
// ****************************************
`define CTL_PLL_EN_BIT      7
`define CTL_FREQ_LSB        3
`define CTL_FREQ_MSB        6
`define CTL_SRC_LSB         0
`define CTL_SRC_MSB         1
`define CTL_RESET           8'h38
`define FREQ_RESET          4'h7
`define SRC_RESET           2'h0

// ****************************************
// Status fields
// ****************************************
`define STS_PLL_READY_BIT   6
`define STS_CFG_CLK_BIT     5
`define STS_HF_READY_BIT    4
`define STS_HF_LOCKED_BIT   3
`define STS_MF_READY_BIT    2
`define STS_LF_READY_BIT    1
`define STS_HF_STABLE_BIT   0

// ****************************************
// Tuning field
// ****************************************
`define TUNE_MSB            5
`define TUNE_RESET          6'h00

// ****************************************
// Frequency select codes
// ****************************************
`define FREQ_HF_16M         4'hF
`define FREQ_HF_8M          4'hE
`define FREQ_HF_MIN         4'h8
`define FREQ_MF_MIN         4'h4
`define FREQ_HF_31K         4'h3
`define FREQ_MF_31K         4'h2

`endif

// ---- hw/osc_ctrl_pkg.sv ----
// Types shared by the oscillator control block.
// Assumes the defs header is compiled alongside.
package osc_ctrl_pkg;

  // Oscillator feeding the internal clock mux
  typedef enum logic [1:0] {
    SRC_CONFIG,
    SRC_HF,
    SRC_MF,
    SRC_LF
  } osc_src_t;

  // Indications from the analog oscillators and fuses
  typedef struct packed {
    logic       config_pll_force;
    logic [1:0] config_osc_select;
    logic       pll_ready;
    logic       hf_ready;
    logic       hf_locked;
    logic       hf_stable;
    logic       mf_ready;
    logic       lf_ready;
    logic       cur_clk_level;
    logic       new_clk_level;
  } osc_analog_t;

  // Clock selection applied to the clock mux
  typedef struct packed {
    logic       use_internal;
    logic [3:0] freq_code;
    logic       pll_on;
  } clk_sel_t;

endpackage

// ---- hw/oscillator_control_status_regs.sv ----
// Oscillator control, status and tuning registers on AHB-Lite.
// Assumes analog ready and clock-level inputs are asynchronous
// and the fuse bits are static after power-up.
//
// How it works
// (R1) Fuse PLL force set: PLL stays enabled, software PLL bit ignored.
// (R2) Fuse PLL force clear: PLL follows the software PLL enable bit.
// (R3) Codes 1111,1101,1100,1011 pick HF oscillator at 16,4,2,1 MHz.
// (R4) Code 1110 gives 8 MHz HF, or 32 MHz via PLL when enabled.
// (R5) Codes 1010,1001,1000 give 500,250,125 kHz from the HF oscillator.
// (R6) Code 0111 gives 500 kHz MF and is loaded on reset.
// (R7) Codes 0110,0101,0100 give 250,125,62.5 kHz from the MF oscillator.
// (R8) 0011 is 31.25 kHz HF, 0010 is 31.25 kHz MF, 000x is 31 kHz LF.
// (R9) Source field 1x picks internal block, 00 the fuse oscillator.
// (R10) Control bit 2 is unimplemented and reads zero.
// (R11) Status bit 6 shows PLL ready.
// (R12) Status bit 5 shows running from the fuse-chosen clock.
// (R13) Status bit 4 shows HF oscillator ready.
// (R14) Status bit 3 shows HF oscillator within 2 percent.
// (R15) Status bit 2 shows MF oscillator ready.
// (R16) Status bit 1 shows LF oscillator ready.
// (R17) Status bit 0 shows HF oscillator within 0.5 percent.
// (R18) Six-bit signed trim, zero is calibrated; upper two bits read zero.
// (R19) Switch waits old clock low, holds gate low, waits new clock high.
// (R20) Source select field clears on every reset.
// (R21) PLL is not applied while the source select field is 1x.
// (R22) Status writes are ignored; bits 6 and 4-0 are synchronised analog indications.
// (R23) Reserved source value 01 runs from the fuse-chosen clock.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "osc_ctrl_defs.svh"

module oscillator_control_status_regs #(
  parameter int SYNC_BITS = 11
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire osc_ctrl_pkg::osc_analog_t analog_in,
  output osc_ctrl_pkg::clk_sel_t         active_sel,
  output osc_ctrl_pkg::osc_src_t         active_src,
  output logic                           sysclk_gate,
  output logic                           pll_enable,
  output logic      [5:0]                freq_trim,
  output logic                           switch_busy
);

  // ****************************************
  // Oscillator decode
  // ****************************************

  // Maps an internal frequency code onto its oscillator
  function automatic osc_ctrl_pkg::osc_src_t freq_to_src(input logic [3:0] code);
    osc_ctrl_pkg::osc_src_t src;
    src = osc_ctrl_pkg::SRC_LF;                                     // R8
    if (code >= `FREQ_HF_MIN)
      src = osc_ctrl_pkg::SRC_HF;                                   // R3
    else if (code >= `FREQ_MF_MIN)
      src = osc_ctrl_pkg::SRC_MF;                                   // R7
    else if (code == `FREQ_HF_31K)
      src = osc_ctrl_pkg::SRC_HF;                                   // R8
    else if (code == `FREQ_MF_31K)
      src = osc_ctrl_pkg::SRC_MF;                                   // R8
    return src;
  endfunction

  // Oscillator that a whole selection runs from
  function automatic osc_ctrl_pkg::osc_src_t sel_to_src(input osc_ctrl_pkg::clk_sel_t sel);
    osc_ctrl_pkg::osc_src_t src;
    src = freq_to_src(sel.freq_code);
    if (!sel.use_internal && sel.freq_code != `FREQ_HF_8M)
      src = osc_ctrl_pkg::SRC_CONFIG;
    if (!sel.use_internal && !sel.pll_on && sel.freq_code == `FREQ_HF_8M)
      src = osc_ctrl_pkg::SRC_CONFIG;
    return src;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************

  logic [SYNC_BITS-1:0] sync_stage1;
  logic [SYNC_BITS-1:0] sync_stage2;
  osc_ctrl_pkg::osc_analog_t ana;

  // Two flops per asynchronous input
  for (genvar i = 0; i < SYNC_BITS; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_stage1[i] <= 1'b0;
        sync_stage2[i] <= 1'b0;
      end else begin
        sync_stage1[i] <= analog_in[i];                             // R22
        sync_stage2[i] <= sync_stage1[i];
      end
    end
  end

  assign ana = osc_ctrl_pkg::osc_analog_t'(sync_stage2);

  // ****************************************
  // Bus address phase
  // ****************************************

  logic        wr_pending;
  logic [11:0] wr_addr;
  logic [7:0]  osc_control;
  logic [5:0]  osc_tuning;
  logic        cfg_clk_flag;

  wire         addr_valid = hsel & hready & htrans[1];
  wire         rd_take    = addr_valid & ~hwrite;
  wire         wr_take    = addr_valid & hwrite;
  wire [11:0]  rd_addr    = haddr[11:0];
  wire         in_range   = (haddr[31:12] == 20'h0_0000);

  // Write decode for the data phase
  wire         wr_ctl  = wr_pending & (wr_addr == `OSC_CONTROL_OFS);
  wire         wr_tune = wr_pending & (wr_addr == `OSC_TUNING_OFS);

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr    <= 12'h000;
    end else begin
      wr_pending <= wr_take & in_range;
      wr_addr    <= haddr[11:0];
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************

  wire [7:0] next_osc_control = wr_ctl ? {hwdata[7:3], 1'b0, hwdata[1:0]} : osc_control; // R10
  wire [5:0] next_osc_tuning  = wr_tune ? hwdata[`TUNE_MSB:0] : osc_tuning;           // R18

  // Control and tuning storage; status has no storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_control <= `CTL_RESET;                                    // R6 R20
      osc_tuning  <= `TUNE_RESET;
    end else begin
      osc_control <= next_osc_control;
      osc_tuning  <= next_osc_tuning;
    end
  end

  // Control fields
  wire       soft_pll_enable      = osc_control[`CTL_PLL_EN_BIT];
  wire [3:0] int_osc_freq_select  = osc_control[`CTL_FREQ_MSB:`CTL_FREQ_LSB];
  wire [1:0] sysclk_source_select = osc_control[`CTL_SRC_MSB:`CTL_SRC_LSB];

  // ****************************************
  // PLL enable and requested selection
  // ****************************************

  wire next_pll_enable = ana.config_pll_force | soft_pll_enable;   // R1 R2
  wire use_internal    = sysclk_source_select[1];                   // R9 R23
  wire pll_allowed     = ~use_internal &                            // R21
                         (int_osc_freq_select == `FREQ_HF_8M) &     // R4
                         (ana.config_osc_select == 2'h0);
  osc_ctrl_pkg::clk_sel_t req_sel;

  assign req_sel.use_internal = use_internal;
  assign req_sel.freq_code    = int_osc_freq_select;
  assign req_sel.pll_on       = next_pll_enable & pll_allowed;      // R4 R21

  // New oscillator readiness, PLL lock when it is in the path
  osc_ctrl_pkg::osc_src_t req_src;
  logic                   req_osc_ready;

  assign req_src = sel_to_src(req_sel);

  always_comb begin
    req_osc_ready = 1'b1;
    unique case (req_src)
      osc_ctrl_pkg::SRC_HF:     req_osc_ready = ana.hf_ready;       // R5
      osc_ctrl_pkg::SRC_MF:     req_osc_ready = ana.mf_ready;
      osc_ctrl_pkg::SRC_LF:     req_osc_ready = ana.lf_ready;
      osc_ctrl_pkg::SRC_CONFIG: req_osc_ready = 1'b1;
    endcase
    if (req_sel.pll_on)
      req_osc_ready = req_osc_ready & ana.pll_ready & ana.hf_ready;
  end

  // ****************************************
  // Clock switch sequencer
  // ****************************************

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_FALL,
    SW_WAIT_RISE
  } switch_state_t;

  switch_state_t sw_state;
  switch_state_t next_sw_state;
  logic          next_gate;
  logic          sel_change;

  assign sel_change = (req_sel != active_sel);

  // Glitch-free handover between old and new clock
  always_comb begin
    next_sw_state = sw_state;
    next_gate     = sysclk_gate;
    unique case (sw_state)
      SW_IDLE: begin
        if (sel_change)
          next_sw_state = SW_WAIT_FALL;
      end
      SW_WAIT_FALL: begin
        if (!ana.cur_clk_level) begin                               // R19
          next_gate     = 1'b0;
          next_sw_state = SW_WAIT_RISE;
        end
      end
      SW_WAIT_RISE: begin
        if (req_osc_ready && ana.new_clk_level) begin               // R19
          next_gate     = 1'b1;
          next_sw_state = SW_IDLE;
        end
      end
      default: begin
        next_sw_state = SW_IDLE;
      end
    endcase
  end

  wire switch_done = (sw_state == SW_WAIT_RISE) & (next_sw_state == SW_IDLE);

  // Sequencer state and gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_state    <= SW_IDLE;
      sysclk_gate <= 1'b1;
    end else begin
      sw_state    <= next_sw_state;
      sysclk_gate <= next_gate;
    end
  end

  // Applied selection, taken over only when the new clock rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_sel  <= '{use_internal: 1'b0, freq_code: `FREQ_RESET, pll_on: 1'b0};
      active_src  <= osc_ctrl_pkg::SRC_CONFIG;
      switch_busy <= 1'b0;
    end else begin
      if (switch_done) begin
        active_sel <= req_sel;                                      // R19
        active_src <= req_src;
      end
      switch_busy <= (next_sw_state != SW_IDLE);
    end
  end

  // ****************************************
  // Analog side outputs
  // ****************************************

  // PLL enable and trim towards the analog blocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_enable <= 1'b0;
      freq_trim  <= `TUNE_RESET;
    end else begin
      pll_enable <= next_pll_enable;                                // R1 R2
      freq_trim  <= next_osc_tuning;                                // R18
    end
  end

  // Running from the fuse clock once the fuse source (not the PLL path) is applied and the fuse select is not 00
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cfg_clk_flag <= 1'b0;
    else
      cfg_clk_flag <= (active_src == osc_ctrl_pkg::SRC_CONFIG) &    // R12
                      (ana.config_osc_select != 2'h0);
  end

  // ****************************************
  // Status register
  // ****************************************

  logic [7:0] osc_status;

  always_comb begin
    osc_status                     = 8'h00;
    osc_status[`STS_PLL_READY_BIT] = ana.pll_ready;                 // R11
    osc_status[`STS_CFG_CLK_BIT]   = cfg_clk_flag;                  // R12
    osc_status[`STS_HF_READY_BIT]  = ana.hf_ready;                  // R13
    osc_status[`STS_HF_LOCKED_BIT] = ana.hf_locked;                 // R14
    osc_status[`STS_MF_READY_BIT]  = ana.mf_ready;                  // R15
    osc_status[`STS_LF_READY_BIT]  = ana.lf_ready;                  // R16
    osc_status[`STS_HF_STABLE_BIT] = ana.hf_stable;                 // R17
  end

  // ****************************************
  // Read mux and response
  // ****************************************

  // Next values so a read right after a write sees the new data
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_range) begin
      unique case (rd_addr)
        `OSC_CONTROL_OFS: rd_mux = {24'h00_0000, next_osc_control};
        `OSC_STATUS_OFS:  rd_mux = {24'h00_0000, osc_status};      // R22
        `OSC_TUNING_OFS:  rd_mux = {26'h000_0000, next_osc_tuning}; // R18
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (rd_take)
        hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// ---- testbench/osc_regs_checker.sv ----
// Concurrent checks on the oscillator register block ports.
// Assumes a single hclk domain and bind onto the design top.
`timescale 1ns/10ps
module osc_regs_checker (
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic [31:0]               hrdata,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire osc_ctrl_pkg::osc_analog_t analog_in,
  input wire osc_ctrl_pkg::clk_sel_t    active_sel,
  input wire osc_ctrl_pkg::osc_src_t    active_src,
  input wire logic                      sysclk_gate,
  input wire logic                      pll_enable,
  input wire logic [5:0]                freq_trim,
  input wire logic                      switch_busy
);
  logic [2:0]  up;
  logic        wr_tune;
  logic        rd_ph;
  logic [31:0] rd_a;
  wire         st = hsel && hready && htrans[1];
  // ****************************************
  // Helper state
  // ****************************************
  // Cycles since reset and data phase trackers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up <= 3'h0;
      wr_tune <= 1'b0;
      rd_ph <= 1'b0;
      rd_a <= 32'h0000_0000;
    end else begin
      up <= up + {2'h0, up != 3'h7};
      wr_tune <= st && hwrite && haddr == 32'h0000_0008;
      rd_ph <= st && !hwrite;
      if (st) rd_a <= haddr;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_pll_force: assert property (up == 3'h7 && $past(analog_in.config_pll_force, 3)
    && $past(analog_in.config_pll_force, 4) |-> pll_enable) else $error("pll not forced on");
  a_trim_write: assert property (wr_tune |=> freq_trim == $past(hwdata[5:0]))
    else $error("trim not written");
  a_rd_fields: assert property (rd_ph |-> hrdata[31:8] == 24'h00_0000 && !(rd_a == 32'h0000_0000
    && hrdata[2]) && !(rd_a == 32'h0000_0008 && |hrdata[7:6]) && !(rd_a == 32'h0000_0004 && hrdata[7]))
    else $error("unimplemented bits not zero");
  a_unmap_zero: assert property (rd_ph && !(rd_a inside {32'h0000_0000, 32'h0000_0004, 32'h0000_0008})
    |-> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_gate_busy: assert property (!sysclk_gate |-> switch_busy) else $error("gate low while idle");
  a_gate_fall: assert property ($fell(sysclk_gate) |-> $past(switch_busy)) else $error("gate fell early");
  a_sel_change: assert property ($changed(active_sel) |-> $rose(sysclk_gate) && $past(switch_busy))
    else $error("selection changed outside switch");
  a_src_map: assert property (active_sel.use_internal |-> active_src == ((active_sel.freq_code[3]
    || active_sel.freq_code == 4'h3) ? osc_ctrl_pkg::SRC_HF : (active_sel.freq_code[2]
    || active_sel.freq_code == 4'h2) ? osc_ctrl_pkg::SRC_MF : osc_ctrl_pkg::SRC_LF))
    else $error("internal source mismatch");
  a_pll_path: assert property (active_sel.pll_on |-> !active_sel.use_internal
    && active_sel.freq_code == 4'hE && active_src == osc_ctrl_pkg::SRC_HF) else $error("pll path wrong");
  a_cfg_src: assert property (!active_sel.use_internal && !active_sel.pll_on
    |-> active_src == osc_ctrl_pkg::SRC_CONFIG) else $error("config source not used");
endmodule

bind oscillator_control_status_regs osc_regs_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .analog_in, .active_sel, .active_src, .sysclk_gate,
  .pll_enable, .freq_trim, .switch_busy);

// ---- testbench/tb_top.sv ----
// Self-checking bench for the oscillator register block.
// Assumes the design package is compiled first; bench drives all ports.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  logic                      hclk = 1'b0;
  logic                      hresetn = 1'b0;
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = 32'h0000_0000;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [31:0]               hwdata = 32'h0000_0000;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  logic                      hresp;
  osc_ctrl_pkg::osc_analog_t ain = 11'h1FC;
  osc_ctrl_pkg::clk_sel_t    active_sel;
  osc_ctrl_pkg::osc_src_t    active_src;
  osc_ctrl_pkg::osc_src_t    exp_src = osc_ctrl_pkg::SRC_CONFIG;
  logic                      sysclk_gate;
  logic                      pll_enable;
  logic                      switch_busy;
  logic [5:0]                freq_trim;
  logic [2:0]                tog = 3'h0;
  logic [31:0]               rd;
  logic [31:0]               seed = 32'h0001_05F0;
  logic [31:0]               tv [3] = '{32'h0000_0020, 32'h0000_001F, 32'h0000_00FF};
  int                        fail_count = 0;
  int                        check_count = 0;
  int                        i;
  // ****************************************
  // Clock, oscillator levels, design
  // ****************************************
  always #10 hclk = ~hclk;
  // Old and new clock levels keep moving
  always @(posedge hclk) begin
    tog <= tog + 3'h1;
    ain.cur_clk_level <= tog[1];
    ain.new_clk_level <= tog[2];
  end
  oscillator_control_status_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .analog_in(ain), .active_sel(active_sel), .active_src(active_src),
    .sysclk_gate(sysclk_gate), .pll_enable(pll_enable), .freq_trim(freq_trim), .switch_busy(switch_busy));
  // ****************************************
  // Model and bus tasks
  // ****************************************
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction
  // Expected status word from oscillator indications
  function automatic logic [31:0] stat();
    return {24'h00_0000, 1'b0, ain.pll_ready, exp_src == osc_ctrl_pkg::SRC_CONFIG && ain.config_osc_select != 2'h0,
      ain.hf_ready, ain.hf_locked, ain.mf_ready, ain.lf_ready, ain.hf_stable};
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 100) begin fail_count++; stop_test(); end
  endtask
  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // Write control, wait for the switch, compare with the model
  task automatic setsel(input logic [7:0] c);
    int n;
    logic pll;
    bus(1'b1, 32'h0000_0000, {24'h00_0000, c});
    repeat (3) @(posedge hclk);
    for (n = 0; n < 200; n++) begin @(negedge hclk); if (switch_busy === 1'b0) break; end
    if (n == 200) begin fail_count++; stop_test(); end
    @(posedge hclk);
    pll = !c[1] && c[6:3] == 4'hE && ain.config_osc_select == 2'h0 && (c[7] || ain.config_pll_force);
    exp_src = !c[1] ? (pll ? osc_ctrl_pkg::SRC_HF : osc_ctrl_pkg::SRC_CONFIG) : (c[6] || c[6:3] == 4'h3)
      ? osc_ctrl_pkg::SRC_HF : (c[5] || c[6:3] == 4'h2) ? osc_ctrl_pkg::SRC_MF : osc_ctrl_pkg::SRC_LF;
    `CHK("source", exp_src, active_src)
    `CHK("selection", {c[1], c[6:3], pll}, active_sel)
    `CHK("gate", 1'b1, sysclk_gate)
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK("control", {24'h00_0000, c[7:3], 1'b0, c[1:0]}, rd)
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK("status", stat(), rd)
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, also after a reset in mid-run
    repeat (2) begin
      @(posedge hclk);
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      `CHK("control reset", 32'h0000_0038, rd)
      bus(1'b0, 32'h0000_0008, 32'h0000_0000);
      `CHK("tuning reset", 32'h0000_0000, rd)
      `CHK("source reset", osc_ctrl_pkg::SRC_CONFIG, active_src)
      // Trim boundaries, unused bits, random values
      for (i = 0; i < 6; i++) begin
        seed = nxt(seed);
        bus(1'b1, 32'h0000_0008, i < 3 ? tv[i] : seed);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        `CHK("tuning", {26'h000_0000, (i < 3 ? tv[i][5:0] : seed[5:0])}, rd)
        `CHK("trim", (i < 3 ? tv[i][5:0] : seed[5:0]), freq_trim)
      end
      // Unmapped places read zero and keep the trim
      bus(1'b1, 32'h0000_000C, 32'h0000_00FF);
      bus(1'b0, 32'h0000_000C, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
      bus(1'b1, 32'h0000_1008, 32'h0000_0015);
      bus(1'b0, 32'h0000_1008, 32'h0000_0000);
      `CHK("high address", 32'h0000_0000, rd)
      bus(1'b0, 32'h0000_0008, 32'h0000_0000);
      `CHK("tuning kept", {26'h000_0000, seed[5:0]}, rd)
      `CHK("trim kept", seed[5:0], freq_trim)
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
    end
    // Every frequency code on the internal block
    for (i = 0; i < 16; i++) begin
      seed = nxt(seed);
      setsel({seed[7], i[3:0], 1'b1, 2'h2});
    end
    setsel(8'h39);
    setsel(8'h70);
    ain.config_osc_select <= 2'h0;
    repeat (4) @(posedge hclk);
    setsel(8'hF0);
    setsel(8'hF2);
    ain.config_osc_select <= 2'h1;
    // Fuse force against the software enable
    for (i = 0; i < 4; i++) begin
      ain.config_pll_force <= i[1];
      repeat (4) @(posedge hclk);
      setsel({i[0], 7'h38});
      repeat (4) @(posedge hclk);
      `CHK("pll enable", i[1] | i[0], pll_enable)
    end
    // Random indications, writes to status ignored
    for (i = 0; i < 8; i++) begin
      seed = nxt(seed);
      {ain.pll_ready, ain.hf_ready, ain.hf_locked, ain.hf_stable, ain.mf_ready, ain.lf_ready} <= seed[5:0];
      repeat (6) @(posedge hclk);
      bus(1'b1, 32'h0000_0004, seed);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000);
      `CHK("status", stat(), rd)
    end
    stop_test();
  end
endmodule
